// ==== mfc_pkg.sv ====
/*
 * Shared constants for the matrix filter control and input front end.
 * Assumes a single 20 MHz system clock; no software-visible registers.
 */
package mfc_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int DATA_W  = 12;
    localparam int COEF_W  = 10;
    localparam int SEL_W   = 2;
    localparam int NTAPS   = 9;
    localparam int FIFO_DEPTH = 16;

    // ************************************************************
    // Configuration selector codes
    // ************************************************************
    localparam logic [1:0] CFG_MATRIX = 2'h0;
    localparam logic [1:0] CFG_FIR9   = 2'h1;
    localparam logic [1:0] CFG_CONV33 = 2'h2;
    localparam logic [1:0] CFG_CONV42 = 2'h3;

    // ************************************************************
    // Coefficient write select codes
    // ************************************************************
    localparam logic [1:0] CWS_HOLD  = 2'h0;
    localparam logic [1:0] CWS_ONE   = 2'h1;
    localparam logic [1:0] CWS_TWO   = 2'h2;
    localparam logic [1:0] CWS_THREE = 2'h3;

    // ************************************************************
    // Timing and reset values
    // ************************************************************
    localparam int          MATRIX_LATENCY = 5;
    localparam int          FLUSH_CYCLES   = 5;
    localparam logic [1:0]  CFG_RESET      = 2'h0;
    localparam logic [11:0] DATA_RESET     = 12'h000;
    localparam logic [9:0]  COEF_RESET     = 10'h000;

    typedef enum logic [1:0] {
        ST_FLUSH,
        ST_RUN
    } run_state_t;

endpackage

// ==== sample_fifo.sv ====
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
module sample_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("sample_fifo depth must be a power of two");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (wr_q - rd_q) != DEPTH[AW:0];
    assign out_valid = wr_q != rd_q;
    assign out_data  = mem[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end
endmodule // sample_fifo

// ==== matrix_filter_control_input.sv ====
/*
 * Control and input front end of a nine-multiplier matrix / filter unit:
 * configuration register with pipeline flush tracking, three sets of
 * coefficient storage, input latching through a sample FIFO, and a
 * nine-position tap shift chain for the filter configurations.
 * Assumes all inputs come from host logic on the same clock.
 */
`timescale 1ns/1ns

module matrix_filter_control_input #(
    parameter int DATA_W = mfc_pkg::DATA_W,
    parameter int COEF_W = mfc_pkg::COEF_W,
    parameter int DEPTH  = mfc_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              resetn,
    // Control
    input  wire logic [1:0]        config_select,
    input  wire logic [1:0]        coef_write_select,
    // Coefficient ports
    input  wire logic [COEF_W-1:0] coef_port_one,
    input  wire logic [COEF_W-1:0] coef_port_two,
    input  wire logic [COEF_W-1:0] coef_port_three,
    // Data input stream
    input  wire logic              data_valid,
    output logic                   data_ready,
    input  wire logic [DATA_W-1:0] data_a,
    input  wire logic [DATA_W-1:0] data_b,
    input  wire logic [DATA_W-1:0] data_c,
    // Configuration status
    output logic [1:0]             config_active,
    output logic                   is_matrix,
    output logic                   is_fir9,
    output logic                   is_conv33,
    output logic                   is_conv42,
    output logic                   pipe_flushed,
    output logic                   matrix_result_valid,
    // Coefficient storage, index 0..2 = port one..three
    output logic [COEF_W-1:0]      coef_reg_set_one   [3],
    output logic [COEF_W-1:0]      coef_reg_set_two   [3],
    output logic [COEF_W-1:0]      coef_reg_set_three [3],
    // Multiplier inputs
    output logic [DATA_W-1:0]      mult_a,
    output logic [DATA_W-1:0]      mult_b,
    output logic [DATA_W-1:0]      mult_c,
    output logic [DATA_W-1:0]      tap_q [mfc_pkg::NTAPS],
    output logic                   sample_strobe
);
    initial begin
        if (DATA_W != mfc_pkg::DATA_W || COEF_W != mfc_pkg::COEF_W) begin
            $error("data and coefficient widths are fixed");
        end
    end

    // ************************************************************
    // Configuration register and flush tracking
    // ************************************************************
    logic [1:0]           cfg_q;
    logic [2:0]           flush_q;
    mfc_pkg::run_state_t  state_q;

    assign is_matrix = cfg_q == mfc_pkg::CFG_MATRIX;
    assign is_fir9   = cfg_q == mfc_pkg::CFG_FIR9;
    assign is_conv33 = cfg_q == mfc_pkg::CFG_CONV33;
    assign is_conv42 = cfg_q == mfc_pkg::CFG_CONV42;
    assign config_active = cfg_q;
    wire cfg_change = config_select != cfg_q;

    // selector taken on one edge, active after it
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= mfc_pkg::CFG_RESET;
        end else begin
            cfg_q <= config_select;
        end
    end

    // flush count the host waits for after a change
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= mfc_pkg::ST_FLUSH;
            flush_q <= '0;
        end else begin
            case (state_q)
                mfc_pkg::ST_FLUSH: begin
                    if (cfg_change) begin
                        flush_q <= '0;
                    end else if (flush_q == 3'(mfc_pkg::FLUSH_CYCLES - 1)) begin
                        state_q <= mfc_pkg::ST_RUN;
                    end else begin
                        flush_q <= flush_q + 3'h1;
                    end
                end
                mfc_pkg::ST_RUN: begin
                    if (cfg_change) begin
                        state_q <= mfc_pkg::ST_FLUSH;
                        flush_q <= '0;
                    end
                end
                default: state_q <= mfc_pkg::ST_FLUSH;
            endcase
        end
    end
    assign pipe_flushed = state_q == mfc_pkg::ST_RUN;

    // ************************************************************
    // Coefficient storage
    // ************************************************************
    // only the write select changes a set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                coef_reg_set_one[i]   <= mfc_pkg::COEF_RESET;
                coef_reg_set_two[i]   <= mfc_pkg::COEF_RESET;
                coef_reg_set_three[i] <= mfc_pkg::COEF_RESET;
            end
        end else begin
            case (coef_write_select)
                mfc_pkg::CWS_ONE: begin
                    coef_reg_set_one[0] <= coef_port_one;
                    coef_reg_set_one[1] <= coef_port_two;
                    coef_reg_set_one[2] <= coef_port_three;
                end
                mfc_pkg::CWS_TWO: begin
                    coef_reg_set_two[0] <= coef_port_one;
                    coef_reg_set_two[1] <= coef_port_two;
                    coef_reg_set_two[2] <= coef_port_three;
                end
                mfc_pkg::CWS_THREE: begin
                    coef_reg_set_three[0] <= coef_port_one;
                    coef_reg_set_three[1] <= coef_port_two;
                    coef_reg_set_three[2] <= coef_port_three;
                end
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Input FIFO and latching
    // ************************************************************
    // The FIFO lets the host burst while the datapath is stalled; the
    // datapath here never stalls, so it drains one sample per clock.
    logic                  f_valid;
    logic [3*DATA_W-1:0]   f_data;
    sample_fifo #(.WIDTH(3*DATA_W), .DEPTH(DEPTH)) u_fifo (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (data_valid),
        .in_ready  (data_ready),
        .in_data   ({data_a, data_b, data_c}),
        .out_valid (f_valid),
        .out_ready (1'b1),
        .out_data  (f_data)
    );

    // latch into the multiplier input registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mult_a        <= mfc_pkg::DATA_RESET;
            mult_b        <= mfc_pkg::DATA_RESET;
            mult_c        <= mfc_pkg::DATA_RESET;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= f_valid;
            if (f_valid) begin
                {mult_a, mult_b, mult_c} <= f_data;
            end
        end
    end

    // tap chain, shifted each edge outside matrix mode
    genvar g;
    generate
        for (g = 0; g < mfc_pkg::NTAPS; g++) begin : g_tap
            wire logic [DATA_W-1:0] tap_in;
            // The link index is only built for taps that have a neighbour.
            if (g == 0) begin : g_head
                assign tap_in = mult_a;
            end else begin : g_link
                assign tap_in = tap_q[g-1];
            end
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    tap_q[g] <= mfc_pkg::DATA_RESET;
                end else if (!is_matrix) begin
                    tap_q[g] <= tap_in;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Matrix result timing
    // ************************************************************
    logic [4:0] lat_sr_q;
    // marks results five clocks after latching
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lat_sr_q <= '0;
        end else begin
            lat_sr_q <= {lat_sr_q[3:0], sample_strobe && is_matrix};
        end
    end
    assign matrix_result_valid = lat_sr_q[4] && is_matrix;

    // ************************************************************
    // Checks
    // ************************************************************
    property p_cfg_next;
        @(posedge clk) disable iff (!resetn)
        1 |=> cfg_q == $past(config_select);
    endproperty
    a_cfg_next: assert property (p_cfg_next) else $error("cfg late");

    property p_flush;
        @(posedge clk) disable iff (!resetn)
        $changed(cfg_q) |-> !pipe_flushed;
    endproperty
    a_flush: assert property (p_flush) else $error("flush missed");

    property p_coef_load;
        @(posedge clk) disable iff (!resetn)
        coef_write_select == mfc_pkg::CWS_TWO |=>
            coef_reg_set_two[1] == $past(coef_port_two);
    endproperty
    a_coef_load: assert property (p_coef_load) else $error("coef load");

    property p_coef_hold;
        @(posedge clk) disable iff (!resetn)
        coef_write_select == mfc_pkg::CWS_HOLD |=>
            $stable(coef_reg_set_one[0]) && $stable(coef_reg_set_three[2]);
    endproperty
    a_coef_hold: assert property (p_coef_hold) else $error("coef moved");

    property p_coef_port;
        @(posedge clk) disable iff (!resetn)
        coef_write_select == mfc_pkg::CWS_THREE |=>
            coef_reg_set_three[0] == $past(coef_port_one)
            && coef_reg_set_three[2] == $past(coef_port_three);
    endproperty
    a_coef_port: assert property (p_coef_port) else $error("coef port");

    property p_latch;
        @(posedge clk) disable iff (!resetn)
        sample_strobe |-> mult_b == $past(f_data[2*DATA_W-1:DATA_W]);
    endproperty
    a_latch: assert property (p_latch) else $error("latch wrong");

    property p_shift;
        @(posedge clk) disable iff (!resetn)
        !is_matrix |=> tap_q[1] == $past(tap_q[0]);
    endproperty
    a_shift: assert property (p_shift) else $error("no shift");

    sequence s_matrix_in;
        sample_strobe && is_matrix;
    endsequence
    property p_latency;
        @(posedge clk) disable iff (!resetn)
        s_matrix_in ##1 is_matrix [*5] |-> matrix_result_valid;
    endproperty
    a_latency: assert property (p_latency) else $error("latency");

    property p_decode;
        @(posedge clk) disable iff (!resetn)
        $past(config_select) == mfc_pkg::CFG_CONV42 |-> is_conv42;
    endproperty
    a_decode: assert property (p_decode) else $error("decode");
endmodule // matrix_filter_control_input

// ==== host_stream_model.sv ====
/*
 * Host-side sample source for the matrix filter front end.
 * Assumes the bench pulses start with a count, spacing and base value.
 */
`timescale 1ns/1ns
module host_stream_model (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Control from the bench
    input  wire logic        start,
    input  wire logic [4:0]  count,
    input  wire logic [1:0]  gap,
    input  wire logic [11:0] base,
    // Sample stream
    output logic             data_valid,
    input  wire logic        data_ready,
    output logic [11:0]      data_a,
    output logic [11:0]      data_b,
    output logic [11:0]      data_c
);
    logic [4:0]  left;
    logic [11:0] idx;
    logic [1:0]  wait_q;
    logic        more;

    assign more = (gap == 2'h0) && (left > 5'h01);

    // Idle data lines toggle so a stale sample never looks valid.
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_valid <= 1'b0;
            left <= 5'h00;
            idx <= 12'h000;
            wait_q <= 2'h0;
            {data_a, data_b, data_c} <= 36'h0;
        end else if (start && left == 5'h00) begin
            left <= count;
            idx <= 12'h000;
            wait_q <= 2'h0;
        end else if (data_valid && data_ready) begin
            idx <= idx + 12'h001;
            left <= left - 5'h01;
            wait_q <= gap;
            data_valid <= more;
            data_a <= more ? base + idx + 12'h001 : ~data_a;
            data_b <= more ? base + idx + 12'h101 : ~data_b;
            data_c <= more ? base + idx + 12'h201 : ~data_c;
        end else if (!data_valid && left != 5'h00 && wait_q == 2'h0) begin
            data_valid <= 1'b1;
            data_a <= base + idx;
            data_b <= base + idx + 12'h100;
            data_c <= base + idx + 12'h200;
        end else if (!data_valid) begin
            if (wait_q != 2'h0) begin
                wait_q <= wait_q - 2'h1;
            end
            {data_a, data_b, data_c} <= ~{data_a, data_b, data_c};
        end
    end
endmodule // host_stream_model

// ==== tb_top.sv ====
/*
 * Self-checking bench for the matrix filter control and input block.
 * Assumes the host model feeds samples; the bench drives control pins.
 */
`timescale 1ns/1ns
module tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  cfg_sel = 2'h0;
    logic [1:0]  cws = 2'h0;
    logic [9:0]  k1 = 10'h000, k2 = 10'h000, k3 = 10'h000;
    logic        start = 1'b0;
    logic [4:0]  cnt = 5'h00;
    logic [1:0]  gap = 2'h0;
    logic [11:0] base = 12'h000;
    logic        dv, dr, sample_strobe, mrv, pipe_flushed;
    logic        is_m, is_f, is_c3, is_c4;
    logic [1:0]  cfg_act;
    logic [11:0] da, db, dc, ma, mb, mc;
    logic [9:0]  s1 [3], s2 [3], s3 [3];
    logic [11:0] taps [mfc_pkg::NTAPS];
    logic [11:0] t0;
    int          fails = 0;
    int          n_tests = 0;

    initial forever #25 clk = ~clk;

    host_stream_model host (.clk(clk), .resetn(resetn), .start(start),
        .count(cnt), .gap(gap), .base(base), .data_valid(dv),
        .data_ready(dr), .data_a(da), .data_b(db), .data_c(dc));

    matrix_filter_control_input uut (.clk(clk), .resetn(resetn),
        .config_select(cfg_sel), .coef_write_select(cws),
        .coef_port_one(k1), .coef_port_two(k2), .coef_port_three(k3),
        .data_valid(dv), .data_ready(dr), .data_a(da), .data_b(db),
        .data_c(dc), .config_active(cfg_act), .is_matrix(is_m),
        .is_fir9(is_f), .is_conv33(is_c3), .is_conv42(is_c4),
        .pipe_flushed(pipe_flushed), .matrix_result_valid(mrv),
        .coef_reg_set_one(s1), .coef_reg_set_two(s2),
        .coef_reg_set_three(s3), .mult_a(ma), .mult_b(mb), .mult_c(mc),
        .tap_q(taps), .sample_strobe(sample_strobe));

    // ************************************************************
    // Compare and wait helpers
    // ************************************************************
    task automatic final_report();
        if (fails == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_val({11'h0, got}, {11'h0, exp});
    endtask

    task automatic wait_until(input int kind, input logic [11:0] a);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (kind == 0 && sample_strobe === 1'b1 && ma === a) return;
            if (kind == 1 && pipe_flushed === 1'b1) return;
        end
        fails++;
        final_report();
    endtask

    task automatic push(input logic [4:0] n, input logic [1:0] g,
                        input logic [11:0] b);
        @(posedge clk);
        start <= 1'b1;
        cnt <= n;
        gap <= g;
        base <= b;
        @(posedge clk);
        start <= 1'b0;
    endtask

    function automatic logic [9:0] cv(input int s, input int p);
        return 10'(s * 16 + p + 512);
    endfunction

    task automatic check_coefs();
        for (int p = 0; p < 3; p++) begin
            cmp_val({2'h0, s1[p]}, {2'h0, cv(1, p)});
            cmp_val({2'h0, s2[p]}, {2'h0, cv(2, p)});
            cmp_val({2'h0, s3[p]}, {2'h0, cv(3, p)});
        end
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_coef();
        for (int s = 1; s <= 3; s++) begin
            @(posedge clk);
            cws <= 2'(s);
            k1 <= cv(s, 0);
            k2 <= cv(s, 1);
            k3 <= cv(s, 2);
        end
        @(posedge clk);
        cws <= mfc_pkg::CWS_HOLD;
        {k1, k2, k3} <= 30'h3FFFFFFF;
        @(posedge clk);
        #1;
        check_coefs();
    endtask

    task automatic t_config();
        logic [1:0] c;
        for (int i = 1; i <= 4; i++) begin
            c = 2'(i);
            @(posedge clk);
            cfg_sel <= c;
            @(posedge clk);
            #1;
            cmp_val({10'h0, cfg_act}, {10'h0, c});
            cmp_bit(is_m, c == mfc_pkg::CFG_MATRIX);
            cmp_bit(is_f, c == mfc_pkg::CFG_FIR9);
            cmp_bit(is_c3, c == mfc_pkg::CFG_CONV33);
            cmp_bit(is_c4, c == mfc_pkg::CFG_CONV42);
            cmp_bit(pipe_flushed, 1'b0);
            for (int k = 1; k <= mfc_pkg::FLUSH_CYCLES; k++) begin
                @(posedge clk);
                #1;
                cmp_bit(pipe_flushed, k == mfc_pkg::FLUSH_CYCLES);
            end
        end
    endtask

    task automatic t_matrix();
        t0 = taps[0];
        cmp_bit(dr, 1'b1);
        push(5'h01, 2'h0, 12'h123);
        wait_until(0, 12'h123);
        cmp_val(mb, 12'h223);
        cmp_val(mc, 12'h323);
        for (int k = 1; k <= mfc_pkg::MATRIX_LATENCY; k++) begin
            @(posedge clk);
            #1;
            cmp_bit(mrv, k == mfc_pkg::MATRIX_LATENCY);
        end
        cmp_val(taps[0], t0);
    endtask

    task automatic t_taps();
        @(posedge clk);
        cfg_sel <= mfc_pkg::CFG_FIR9;
        wait_until(1, 12'h000);
        push(5'h09, 2'h0, 12'h400);
        wait_until(0, 12'h408);
        @(posedge clk);
        #1;
        for (int k = 0; k < mfc_pkg::NTAPS; k++) begin
            cmp_val(taps[k], 12'(12'h408 - k));
        end
        push(5'h03, 2'h2, 12'h700);
        wait_until(0, 12'h702);
        cmp_val(mc, 12'h902);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        #1;
        cmp_val({10'h0, cfg_act}, {10'h0, mfc_pkg::CFG_RESET});
        cmp_bit(pipe_flushed, 1'b0);
        t_coef();
        t_config();
        check_coefs();
        t_matrix();
        t_taps();
        final_report();
    end
endmodule // tb_top
